/* File: rtl/guard_map.svh */
// Offsets, edge counts and timing figures of the write-guard block
`ifndef GUARD_MAP_SVH
`define GUARD_MAP_SVH

`define CLK_PERIOD_NS      50
`define PROG_TIME_NS       4000000
`define PROG_CYCLES        (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define LATCH_DECIDE_EDGE  16'h0007
`define OPCODE_EDGES       16'h0008
`define STATUS_FIRE_EDGE   16'h0010
`define ARRAY_FIRST_EDGE   16'h0020
`define SET_LATCH_OPCODE   8'h06
`define CLR_LATCH_OPCODE   8'h04
`define STATUS_WRITE_OPC   8'h01
`define STATUS_READ_OPC    8'h03
`define ARRAY_WRITE_OPC    8'h02
`define LATCH_RESET        1'b0

`endif

/* File: rtl/guard_pkg.sv */
// Types shared by the write-guard block
package guard_pkg;

    typedef enum logic [1:0] {PH_IDLE, PH_OPCODE, PH_BODY} phase_t;

    typedef struct packed {
        logic cs_low;
        logic sck;
        logic si;
    } serial_pins_t;

    typedef struct packed {
        phase_t      phase;
        logic        sck_prev;
        logic        cs_prev;
        logic [7:0]  opcode;
        logic [15:0] edges;
        logic        latch;
        logic        busy;
        logic        start;
        logic        start_status;
        logic        rejected;
    } guard_state_t;

    typedef struct packed {
        logic [23:0] count;
        logic        running;
        logic        done;
    } timer_state_t;

endpackage : guard_pkg

/* File: rtl/program_timer.sv */
// Self-timed program cycle counter
`timescale 1ns/1ns
module program_timer #(
    parameter int unsigned CYCLES = 80000
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic start,
    output logic      done
);
    guard_pkg::timer_state_t s;
    guard_pkg::timer_state_t next_s;

    // Load on start, count down, pulse done at zero
    always_comb
    begin
        next_s = s;
        next_s.done = 1'b0;
        if (start)
        begin
            next_s.count = 24'(CYCLES - 1);
            next_s.running = 1'b1;
        end
        else if (s.running)
        begin
            if (s.count == 24'h00_0000)
            begin
                next_s.running = 1'b0;
                next_s.done = 1'b1;
            end
            else
            begin
                next_s.count = s.count - 24'h00_0001;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s <= '0;
        else
            s <= next_s;
    end

    assign done = s.done;
endmodule : program_timer

/* File: rtl/eeprom_write_guard_cancel.sv */
// Write-guard and command-cancel control of a serial EEPROM
`timescale 1ns/1ns
`include "guard_map.svh"
module eeprom_write_guard_cancel #(
    parameter int unsigned PROG_CYCLES  = `PROG_CYCLES,
    parameter logic [7:0]  SET_OPC      = `SET_LATCH_OPCODE,
    parameter logic [7:0]  CLR_OPC      = `CLR_LATCH_OPCODE,
    parameter logic [7:0]  STAT_WR_OPC  = `STATUS_WRITE_OPC,
    parameter logic [7:0]  STAT_RD_OPC  = `STATUS_READ_OPC,
    parameter logic [7:0]  ARRAY_WR_OPC = `ARRAY_WRITE_OPC
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire guard_pkg::serial_pins_t pins,
    input  wire logic                    low_supply_lockout,
    output logic                         write_latch,
    output logic                         program_busy,
    output logic                         write_start,
    output logic                         write_is_status,
    output logic                         command_rejected
);
    guard_pkg::guard_state_t s;
    guard_pkg::guard_state_t next_s;
    logic                    timer_done;
    logic                    sck_rise;
    logic                    cs_rise;
    logic                    selected;
    logic                    can_write;
    logic [6:0]              first_seven;
    logic [7:0]              full_opcode;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the sampled pins
    assign selected    = ~pins.cs_low;
    assign sck_rise    = pins.sck & ~s.sck_prev;
    assign cs_rise     = pins.cs_low & ~s.cs_prev;
    assign first_seven = {s.opcode[5:0], pins.si};
    assign full_opcode = {s.opcode[6:0], pins.si};
    assign can_write   = s.latch & ~low_supply_lockout & ~s.busy;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode and write guard
    always_comb
    begin
        next_s = s;
        next_s.start = 1'b0;
        next_s.rejected = 1'b0;
        next_s.sck_prev = pins.sck;
        next_s.cs_prev = pins.cs_low;
        // End of the program cycle frees the guard; a release in this same cycle still sees busy and is refused
        if (timer_done)
            next_s.busy = 1'b0;
        if (!selected)
        begin
            // Select rise decides whether a pending write fires
            if (cs_rise && s.phase == guard_pkg::PH_BODY)
            begin
                if (s.opcode == STAT_WR_OPC && s.edges == `STATUS_FIRE_EDGE)
                begin
                    next_s.start = can_write;
                    next_s.start_status = 1'b1;
                    next_s.rejected = ~can_write;
                end
                else if (s.opcode == ARRAY_WR_OPC && s.edges >= `ARRAY_FIRST_EDGE
                         && s.edges[2:0] == 3'h0)
                begin
                    next_s.start = can_write;
                    next_s.start_status = 1'b0;
                    next_s.rejected = ~can_write;
                end
                if (can_write && (next_s.start))
                    next_s.busy = 1'b1;
            end
            // Abandon anything partially received
            next_s.phase = guard_pkg::PH_IDLE;
            next_s.edges = 16'h0000;
            next_s.opcode = 8'h00;
        end
        else
        begin
            if (s.phase == guard_pkg::PH_IDLE)
                next_s.phase = guard_pkg::PH_OPCODE;
            if (sck_rise)
            begin
                next_s.edges = s.edges + 16'h0001;
                if (s.edges < `OPCODE_EDGES)
                    next_s.opcode = full_opcode;
                // Seventh edge commits latch commands
                if (s.edges == `LATCH_DECIDE_EDGE - 16'h0001)
                begin
                    if (first_seven == SET_OPC[7:1] || first_seven == CLR_OPC[7:1])
                    begin
                        if (s.busy)
                            next_s.rejected = 1'b1;
                        else
                            next_s.latch = (first_seven == SET_OPC[7:1]);
                    end
                end
                if (s.edges == `OPCODE_EDGES - 16'h0001)
                begin
                    next_s.phase = guard_pkg::PH_BODY;
                    if (s.busy && full_opcode != STAT_RD_OPC)
                        next_s.rejected = 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; latch starts clear
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s <= '0;
            s.latch <= `LATCH_RESET;
            s.cs_prev <= 1'b1; // Idle select level, no false rise after reset
        end
        else
        begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program cycle timer
    program_timer #(
        .CYCLES (PROG_CYCLES)
    ) u_timer (
        .clk   (clk),
        .rstn  (rstn),
        .start (s.start),
        .done  (timer_done)
    );

    // Outputs straight from state flops
    assign write_latch      = s.latch;
    assign program_busy     = s.busy;
    assign write_start      = s.start;
    assign write_is_status  = s.start_status;
    assign command_rejected = s.rejected;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // A latch command released before its deciding edge
    sequence early_release;
        s.phase != guard_pkg::PH_IDLE && cs_rise && s.edges < `LATCH_DECIDE_EDGE;
    endsequence

    // The deciding edge of a latch command while no program cycle runs
    sequence seventh_edge;
        selected && sck_rise && s.edges == `LATCH_DECIDE_EDGE - 16'h0001 && !s.busy;
    endsequence

    // Latch decisions
    a_early_cancel_keep: assert property (early_release |=> $stable(s.latch))
        else $error("latch changed by cancelled command");
    a_seventh_set_latch: assert property (
        seventh_edge ##0 (first_seven == SET_OPC[7:1]) |=> s.latch [*8])
        else $error("set command lost after seventh edge");
    a_seventh_clr_latch: assert property (
        seventh_edge ##0 (first_seven == CLR_OPC[7:1]) |=> !s.latch)
        else $error("clear command did not clear latch");
    a_busy_latch_hold: assert property (
        s.busy && selected && sck_rise && s.edges == `LATCH_DECIDE_EDGE - 16'h0001
        |=> $stable(s.latch))
        else $error("latch changed during program cycle");

    // Reset state
    a_reset_latch_clear: assert property (
        $rose(rstn) |-> !s.latch)
        else $error("latch set after reset");

    // Edge counting and deselect
    a_count_when_low: assert property (
        selected && sck_rise && s.edges < 16'h0100 |=> s.edges == $past(s.edges) + 16'h0001)
        else $error("edge not counted while selected");
    a_ignore_when_high: assert property (
        pins.cs_low |=> s.edges == 16'h0000 && s.phase == guard_pkg::PH_IDLE)
        else $error("input kept while deselected");

    // Write start guards
    a_status_fire_edge: assert property (
        s.start && s.start_status |-> $past(s.edges) == `STATUS_FIRE_EDGE)
        else $error("status write started off its window");
    a_start_on_release: assert property (
        s.start |-> $past(cs_rise) && $past(s.phase) == guard_pkg::PH_BODY)
        else $error("write started without a select release");
    a_start_guarded: assert property (
        s.start |-> $past(s.latch) && !$past(low_supply_lockout) && !$past(s.busy))
        else $error("write started while blocked");
    a_lockout_no_start: assert property (
        low_supply_lockout |=> !s.start)
        else $error("write started under supply lockout");
    a_lockout_rejects: assert property (
        low_supply_lockout && cs_rise && s.phase == guard_pkg::PH_BODY
        && s.opcode == STAT_WR_OPC && s.edges == `STATUS_FIRE_EDGE |=> command_rejected)
        else $error("blocked status write not refused");

    // Program cycle
    a_busy_no_restart: assert property (
        s.start |=> s.busy ##1 (!s.start)[*3])
        else $error("program cycle restarted or not busy");
    a_busy_from_start: assert property (
        $rose(s.busy) |-> s.start)
        else $error("program cycle began without a write start");
    a_busy_rejects: assert property (
        s.busy && selected && sck_rise && s.edges == `OPCODE_EDGES - 16'h0001
        && full_opcode != STAT_RD_OPC |=> command_rejected)
        else $error("command accepted during program cycle");
endmodule : eeprom_write_guard_cancel

/* File: verif/host_model.sv */
// Host model that drives the serial pins of the write guard
`timescale 1ns/1ns
module host_model (
    input  wire logic               clk,
    output guard_pkg::serial_pins_t pins
);
    // Select high and clock low from time zero
    initial pins = '{cs_low: 1'b1, sck: 1'b0, si: 1'b0};

    // A deselected data line shows no stale value
    always @(negedge clk)
        if (pins.cs_low === 1'b1)
            pins.si <= ~pins.si;

    ////////////////////////////////////////////////////////////////////////
    // One framed command, MSB first, released while the clock is low
    task automatic frame(input logic [31:0] bits, input int n);
        pins.cs_low = 1'b0;
        @(negedge clk);
        for (int i = n - 1; i >= 0; i--)
        begin
            pins.sck = 1'b0;
            pins.si  = bits[i];
            repeat (2) @(negedge clk);
            pins.sck = 1'b1;
            repeat (2) @(negedge clk);
        end
        pins.sck = 1'b0;
        repeat (2) @(negedge clk);
        pins.cs_low = 1'b1;
        repeat (4) @(negedge clk);
    endtask : frame

    // Clock activity while deselected
    task automatic noise(input int n);
        repeat (n)
        begin
            pins.sck = ~pins.sck;
            @(negedge clk);
        end
    endtask : noise
endmodule : host_model

/* File: verif/eeprom_write_guard_cancel_test.sv */
// Self-checking testbench of the write-guard block
`timescale 1ns/1ns
module eeprom_write_guard_cancel_test;
    logic                    clk = 1'b0;
    logic                    rstn = 1'b0;
    logic                    low_supply_lockout = 1'b0;
    guard_pkg::serial_pins_t pins;
    logic                    write_latch;
    logic                    program_busy;
    logic                    write_start;
    logic                    write_is_status;
    logic                    command_rejected;
    int                      bad_count = 0;
    int                      tests_run = 0;
    int                      starts = 0;
    int                      stat_starts = 0;
    int                      rejects = 0;

    // 20 MHz clock
    always #25 clk = ~clk;

    host_model host (.clk(clk), .pins(pins));

    eeprom_write_guard_cancel #(.PROG_CYCLES(200)) uut (
        .clk                (clk),
        .rstn               (rstn),
        .pins               (pins),
        .low_supply_lockout (low_supply_lockout),
        .write_latch        (write_latch),
        .program_busy       (program_busy),
        .write_start        (write_start),
        .write_is_status    (write_is_status),
        .command_rejected   (command_rejected)
    );

    // Counts the one-cycle pulses mid-cycle, where they have settled
    always @(negedge clk)
    begin
        if (write_start === 1'b1)
            starts++;
        if (write_start === 1'b1 && write_is_status === 1'b1)
            stat_starts++;
        if (command_rejected === 1'b1)
            rejects++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic check_num(input string what, input int exp, input int got);
        tests_run++;
        if (got != exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask : check_num

    task automatic zero;
        starts = 0;
        stat_starts = 0;
        rejects = 0;
    endtask : zero

    task automatic wait_idle;
        for (int i = 0; i < 400 && program_busy !== 1'b0; i++)
            @(negedge clk);
        check_bit("busy end", 1'b0, program_busy);
    endtask : wait_idle

    ////////////////////////////////////////////////////////////////////////
    task automatic test_latch;
        check_bit("latch after reset", 1'b0, write_latch);
        host.frame(32'h0000_0001, 6);
        check_bit("set cut early", 1'b0, write_latch);
        host.frame(32'h0000_0003, 7);
        check_bit("set cut late", 1'b1, write_latch);
        host.frame(32'h0000_0001, 6);
        check_bit("clear cut early", 1'b1, write_latch);
        host.frame(32'h0000_0004, 8);
        check_bit("clear full", 1'b0, write_latch);
        zero();
        host.noise(40);
        check_bit("noise latch", 1'b0, write_latch);
        check_num("noise starts", 0, starts + rejects);
        host.frame(32'h0000_0006, 8);
        check_bit("set full", 1'b1, write_latch);
        $display("test_latch done");
    endtask : test_latch

    task automatic test_status;
        zero();
        host.frame(32'h0000_0080, 15);
        host.frame(32'h0000_0202, 17);
        check_num("early or late status", 0, starts);
        host.frame(32'h0000_0100, 16);
        check_num("status start", 1, stat_starts);
        check_bit("busy", 1'b1, program_busy);
        host.frame(32'h0000_0004, 8);
        // Refused at its deciding edge and again at the end of the opcode
        check_num("busy reject", 2, rejects);
        check_bit("latch kept", 1'b1, write_latch);
        host.frame(32'h0000_0003, 8);
        check_num("status read", 2, rejects);
        wait_idle();
        $display("test_status done");
    endtask : test_status

    task automatic test_lockout;
        zero();
        low_supply_lockout = 1'b1;
        host.frame(32'h0000_0100, 16);
        check_num("lockout start", 0, starts);
        check_num("lockout reject", 1, rejects);
        low_supply_lockout = 1'b0;
        host.frame(32'h0200_00a5, 32);
        check_num("array start", 1, starts);
        check_num("array kind", 0, stat_starts);
        wait_idle();
        host.frame(32'h0000_0004, 8);
        host.frame(32'h0200_00a5, 32);
        check_num("no latch start", 1, starts);
        check_num("no latch reject", 2, rejects);
        $display("test_lockout done");
    endtask : test_lockout

    // Supply lost during a program cycle, then the host writes again
    task automatic test_power_loss;
        host.frame(32'h0000_0006, 8);
        host.frame(32'h0000_0100, 16);
        check_bit("busy before loss", 1'b1, program_busy);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        check_bit("latch after loss", 1'b0, write_latch);
        check_bit("busy after loss", 1'b0, program_busy);
        zero();
        host.frame(32'h0000_0006, 8);
        host.frame(32'h0000_0100, 16);
        check_num("rewrite start", 1, stat_starts);
        wait_idle();
        $display("test_power_loss done");
    endtask : test_power_loss

    task automatic results;
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    // Main sequence
    initial
    begin
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        test_latch();
        test_status();
        test_lockout();
        test_power_loss();
        results();
    end

    // Watchdog
    initial
    begin
        #(50 * 8000);
        bad_count++;
        results();
    end
endmodule : eeprom_write_guard_cancel_test
